// [rtl/anc_pkg.sv]
package anc_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REQ = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DATA0 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DATA1 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_DATA2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STAT = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h1c;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int REQ_SLOT_LSB = 0;
    localparam int REQ_SUB_LSB = 8;
    localparam int REQ_PARAM_LSB = 16;
    localparam int REQ_INDEX_LSB = 24;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_OK_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_NOK_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] REQ_RESET = 32'h0101_0100;

    // ****************************************
    // record request decoding
    // ****************************************
    localparam logic [7:0] SLOT_SEG1 = 8'h00;
    localparam logic [7:0] SLOT_SEG2 = 8'h64;
    localparam logic [7:0] SUBSLOT_ID = 8'h01;
    localparam logic [7:0] REQ_PARAM = 8'h01;
    localparam logic [7:0] IDX_NODE_PTR = 8'h44;
    localparam logic [7:0] IDX_SET_PCFG = 8'h08;
    localparam logic [7:0] IDX_GET_PCFG = 8'h09;
    localparam logic [7:0] IDX_GET_ACFG = 8'h0b;
    localparam logic [7:0] IDX_SET_LPS = 8'h0c;
    localparam logic [7:0] IDX_GET_LPS = 8'h0d;
    localparam logic [7:0] IDX_GET_LAS = 8'h0e;
    localparam logic [7:0] IDX_GET_LDS = 8'h0f;
    localparam logic [7:0] STS_OK = 8'h00;
    localparam logic [7:0] STS_NOK = 8'h01;
    localparam int PTR_BYTE = 2;
    localparam int CFG_WR_BYTE = 4;
    localparam int CFG_RD_BYTE = 2;
    localparam int LIST_BYTE = 2;
    localparam int STS_BYTE = 11;
    localparam logic [63:0] LIST_MASK = 64'hffff_fffe_ffff_fffe;

    typedef enum logic {ANC_IDLE, ANC_EXEC} anc_state_t;
endpackage : anc_pkg

// [rtl/anc_cmd_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface anc_cmd_if;
    logic start;
    logic wr;
    logic [7:0] slot;
    logic [7:0] subslot;
    logic [7:0] param;
    logic [7:0] index;
    logic [95:0] wdata;
    logic [95:0] rdata;
    logic done;
    logic ok;
    logic master_ok;
    logic [127:0] act_list;
    logic [127:0] det_list;
    logic [15:0] act_cfg;
    logic [5:0] cfg_node;
    logic cfg_seg;
    modport host(output start, wr, slot, subslot, param, index, wdata, master_ok, act_list,
                 det_list, act_cfg, input rdata, done, ok, cfg_node, cfg_seg);
    modport exec(input start, wr, slot, subslot, param, index, wdata, master_ok, act_list,
                 det_list, act_cfg, output rdata, done, ok, cfg_node, cfg_seg);
endinterface : anc_cmd_if
`default_nettype wire

// [rtl/anc_exec.sv]
`timescale 1ns/1ns
`default_nettype none
module anc_exec (
    input wire logic clk_i,
    input wire logic arst_n_i,
    anc_cmd_if.exec cmd
);
    import anc_pkg::*;

    anc_state_t state_q;
    logic wr_q;
    logic [7:0] slot_q, sub_q, par_q, idx_q;
    logic [95:0] wdata_q;
    logic [5:0] ptr_q [2];
    logic [63:0] lps_q [2];
    logic [15:0] pcfg_q [128];
    logic [5:0] cfg_node_q;
    logic cfg_seg_q, done_q, ok_q;
    logic [95:0] rdata_q;
    logic seg, slot_ok, hdr_ok, is_list, exec_ok, start_seg;
    logic [63:0] list_sel;
    logic [95:0] resp;

    // ****************************************
    // request decode
    // ****************************************
    always_comb begin
        seg = (slot_q == SLOT_SEG2);
        slot_ok = (slot_q == SLOT_SEG1) || seg; // [R1]
        hdr_ok = (sub_q == SUBSLOT_ID) && (par_q == REQ_PARAM); // [R2]
        start_seg = (cmd.slot == SLOT_SEG2);
        is_list = !wr_q && (idx_q == IDX_GET_LPS || idx_q == IDX_GET_LAS ||
                            idx_q == IDX_GET_LDS);
        list_sel = lps_q[seg]; // [R8]
        if (idx_q == IDX_GET_LAS) begin
            list_sel = seg ? cmd.act_list[127:64] : cmd.act_list[63:0]; // [R9]
        end else if (idx_q == IDX_GET_LDS) begin
            list_sel = seg ? cmd.det_list[127:64] : cmd.det_list[63:0]; // [R10] [R11]
        end
        exec_ok = 1'b0;
        resp = '0;
        // anything not decoded below stays NOK with nothing stored
        if (slot_ok && hdr_ok) begin // [R14]
            if (wr_q) begin
                if (idx_q == IDX_NODE_PTR) begin
                    exec_ok = 1'b1;
                end else if (idx_q == IDX_SET_PCFG || idx_q == IDX_SET_LPS) begin
                    exec_ok = cmd.master_ok; // [R12] [R13]
                end
            end else if (idx_q == IDX_GET_PCFG) begin
                exec_ok = 1'b1;
                // stored word is write bytes 4 and 5 in order, so it lands as bytes 2 and 3
                resp[8*CFG_RD_BYTE +: 16] = pcfg_q[{seg, ptr_q[seg]}]; // [R5]
            end else if (idx_q == IDX_GET_ACFG) begin
                exec_ok = 1'b1;
                resp[8*CFG_RD_BYTE +: 16] = {cmd.act_cfg[7:0], cmd.act_cfg[15:8]}; // [R6]
            end else if (is_list) begin
                exec_ok = 1'b1;
                resp[8*LIST_BYTE +: 64] = list_sel & LIST_MASK;
            end
        end
        if (is_list) begin
            resp[8*STS_BYTE +: 8] = exec_ok ? STS_OK : STS_NOK; // [R8] [R9] [R11] [R13]
        end
    end

    // ****************************************
    // sequencing
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ANC_IDLE;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            case (state_q)
                ANC_IDLE: begin
                    done_q <= 1'b0;
                    if (cmd.start) begin
                        state_q <= ANC_EXEC;
                    end
                end
                ANC_EXEC: begin
                    done_q <= 1'b1;
                    ok_q <= exec_ok;
                    rdata_q <= resp;
                    state_q <= ANC_IDLE;
                end
                default: state_q <= ANC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_q <= 1'b0;
            slot_q <= '0;
            sub_q <= '0;
            par_q <= '0;
            idx_q <= '0;
            wdata_q <= '0;
            cfg_node_q <= '0;
            cfg_seg_q <= 1'b0;
        end else if (state_q == ANC_IDLE && cmd.start) begin
            wr_q <= cmd.wr;
            slot_q <= cmd.slot;
            sub_q <= cmd.subslot;
            par_q <= cmd.param;
            idx_q <= cmd.index;
            wdata_q <= cmd.wdata;
            cfg_node_q <= ptr_q[start_seg]; // [R3]
            cfg_seg_q <= start_seg;
        end
    end

    // ****************************************
    // stored configuration
    // ****************************************
    // writes to 0x08 and 0x0C only land once the master side reports the operation took effect; a pointer write to 0x44 with a good slot and header always lands
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_q <= '{default: '0};
            lps_q <= '{default: '0};
            pcfg_q <= '{default: '0};
        end else if (state_q == ANC_EXEC && wr_q && exec_ok) begin
            if (idx_q == IDX_NODE_PTR) begin
                ptr_q[seg] <= wdata_q[8*PTR_BYTE +: 6]; // [R3]
            end else if (idx_q == IDX_SET_PCFG) begin
                pcfg_q[{seg, ptr_q[seg]}] <= wdata_q[8*CFG_WR_BYTE +: 16]; // [R4]
            end else begin
                lps_q[seg] <= wdata_q[8*LIST_BYTE +: 64] & LIST_MASK; // [R7]
            end
        end
    end

    assign cmd.done = done_q;
    assign cmd.ok = ok_q;
    assign cmd.rdata = rdata_q;
    assign cmd.cfg_node = cfg_node_q;
    assign cmd.cfg_seg = cfg_seg_q;

    chk_bad_req_nok: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R14]
        state_q == ANC_IDLE && cmd.start && cmd.slot != SLOT_SEG1 && cmd.slot != SLOT_SEG2
        |=> ##1 done_q && !ok_q)
        else $error("bad slot not answered NOK");
    chk_write_status: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
        state_q == ANC_EXEC && wr_q && slot_ok && hdr_ok && idx_q == IDX_SET_LPS
        |=> ok_q == $past(cmd.master_ok))
        else $error("write status differs from master outcome");
    chk_ptr_select: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R3]
        state_q == ANC_IDLE && cmd.start |=> cfg_node_q == $past(ptr_q[start_seg]))
        else $error("node pointer not applied");
    chk_list_status: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R8]
        state_q == ANC_EXEC && is_list
        |=> rdata_q[8*STS_BYTE +: 8] == (ok_q ? STS_OK : STS_NOK))
        else $error("list status byte wrong");
    chk_acfg_layout: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R6]
        state_q == ANC_EXEC && !wr_q && idx_q == IDX_GET_ACFG && slot_ok && hdr_ok
        |=> rdata_q[23:16] == $past(cmd.act_cfg[15:8]) && rdata_q[31:24] ==
            $past(cmd.act_cfg[7:0]) && rdata_q[15:0] == 16'h0000)
        else $error("actual configuration layout wrong");
    chk_lps_store: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R7]
        state_q == ANC_EXEC && wr_q && idx_q == IDX_SET_LPS && exec_ok
        |=> lps_q[$past(seg)] == ($past(wdata_q[79:16]) & LIST_MASK))
        else $error("projected list not stored");
endmodule : anc_exec
`default_nettype wire

// [rtl/anc_top.sv]
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1 - slot 0 selects the first segment and slot 100 the second.
// R2 - every request carries subslot 0x01 and request parameter 0x01.
// R3 - a write to record 0x44 sets the node pointer that later per-node commands use.
// R4 - record write 0x08 stores the pointed node's permanent configuration from bytes 4 and 5.
// R5 - record read 0x09 returns the stored configuration in bytes 2 and 3, bytes 0 and 1 zero.
// R6 - record read 0x0B returns the actual node configuration in bytes 2 and 3, high byte in byte 2, bytes 0 and 1 zero.
// R7 - record write 0x0C stores the projected list bitmap with bit 0 of bytes 2 and 6 unused.
// R8 - record read 0x0D returns the projected list with the status in byte 11.
// R9 - record read 0x0E returns the activated list with the status in byte 11.
// R10 - the detected list command returns the bitmap of available nodes.
// R11 - the detected list is served at read index 0x0F with the status in byte 11.
// R12 - a write's status to 0x08 or 0x0C equals the outcome reported by the master side; a write to 0x44 with a good slot and header is always OK.
// R13 - status is OK when the operation took effect and NOK otherwise.
// R14 - bad slot or unsupported index answers NOK and changes nothing stored.
module anc_top (
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [anc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [anc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic MASTER_OK_I,
    input wire logic [127:0] ACT_LIST_I,
    input wire logic [127:0] DET_LIST_I,
    input wire logic [15:0] ACT_CFG_I,
    output logic [5:0] CFG_NODE_O,
    output logic CFG_SEG_O,
    output logic IRQ_O
);
    import anc_pkg::*;

    anc_cmd_if cmd ();

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic do_wr, wr_hit;
    logic [31:0] rd_val;
    logic rd_hit;
    logic start_q, wr_mode_q, busy_q, ok_q;
    logic [31:0] req_q;
    logic [95:0] wbuf_q, resp_q;
    logic [1:0] istat_q, imask_q, ievt, iclr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    // ****************************************
    // bus slave: address and data taken in either order
    // ****************************************
    assign do_wr = !awready_q && !wready_q && !bvalid_q;

    always_comb begin
        wr_hit = (awaddr_q == OFS_CTRL) || (awaddr_q == OFS_REQ) || (awaddr_q == OFS_DATA0) ||
                 (awaddr_q == OFS_DATA1) || (awaddr_q == OFS_DATA2) ||
                 (awaddr_q == OFS_IRQ_STAT) || (awaddr_q == OFS_IRQ_MASK);
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (S_AXI_AWVALID_I && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q <= {S_AXI_AWADDR_I[ADDR_W-1:2], 2'h0};
            end
            if (S_AXI_WVALID_I && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end
            if (do_wr) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && S_AXI_BREADY_I) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_CTRL[ADDR_W-1:2]) begin
            rd_val[CTRL_WR_BIT] = wr_mode_q;
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_REQ[ADDR_W-1:2]) begin
            rd_val = req_q;
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_DATA0[ADDR_W-1:2]) begin
            rd_val = resp_q[31:0];
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_DATA1[ADDR_W-1:2]) begin
            rd_val = resp_q[63:32];
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_DATA2[ADDR_W-1:2]) begin
            rd_val = resp_q[95:64];
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_STAT[ADDR_W-1:2]) begin
            rd_val[STAT_BUSY_BIT] = busy_q;
            rd_val[STAT_OK_BIT] = ok_q;
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_IRQ_STAT[ADDR_W-1:2]) begin
            rd_val[1:0] = istat_q;
        end else if (S_AXI_ARADDR_I[ADDR_W-1:2] == OFS_IRQ_MASK[ADDR_W-1:2]) begin
            rd_val[1:0] = imask_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (S_AXI_ARVALID_I && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && S_AXI_RREADY_I) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ****************************************
    // request registers and command launch
    // ****************************************
    // a go while a command runs is dropped, so the request buffer is never torn
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            start_q <= 1'b0;
            wr_mode_q <= 1'b0;
            busy_q <= 1'b0;
            req_q <= REQ_RESET;
            wbuf_q <= '0;
        end else begin
            start_q <= 1'b0;
            if (cmd.done) begin
                busy_q <= 1'b0;
            end
            if (do_wr && awaddr_q == OFS_CTRL && wstrb_q[0] && !busy_q) begin
                wr_mode_q <= wdata_q[CTRL_WR_BIT];
                if (wdata_q[CTRL_GO_BIT]) begin
                    start_q <= 1'b1;
                    busy_q <= 1'b1;
                end
            end
            if (do_wr && awaddr_q == OFS_REQ) begin
                req_q <= merge(req_q, wdata_q, wstrb_q);
            end
            if (do_wr && awaddr_q == OFS_DATA0) begin
                wbuf_q[31:0] <= merge(wbuf_q[31:0], wdata_q, wstrb_q);
            end
            if (do_wr && awaddr_q == OFS_DATA1) begin
                wbuf_q[63:32] <= merge(wbuf_q[63:32], wdata_q, wstrb_q);
            end
            if (do_wr && awaddr_q == OFS_DATA2) begin
                wbuf_q[95:64] <= merge(wbuf_q[95:64], wdata_q, wstrb_q);
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            resp_q <= '0;
            ok_q <= 1'b0;
        end else if (cmd.done) begin
            resp_q <= cmd.rdata; // [R5]
            ok_q <= cmd.ok; // [R13]
        end
    end

    assign cmd.start = start_q;
    assign cmd.wr = wr_mode_q;
    assign cmd.slot = req_q[REQ_SLOT_LSB +: 8];
    assign cmd.subslot = req_q[REQ_SUB_LSB +: 8];
    assign cmd.param = req_q[REQ_PARAM_LSB +: 8];
    assign cmd.index = req_q[REQ_INDEX_LSB +: 8];
    assign cmd.wdata = wbuf_q;
    assign cmd.master_ok = MASTER_OK_I;
    assign cmd.act_list = ACT_LIST_I;
    assign cmd.det_list = DET_LIST_I;
    assign cmd.act_cfg = ACT_CFG_I;

    anc_exec u_exec (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .cmd(cmd)
    );

    // ****************************************
    // interrupts
    // ****************************************
    // a new event in the clearing cycle keeps its bit set
    always_comb begin
        ievt = '0;
        ievt[IRQ_DONE_BIT] = cmd.done;
        ievt[IRQ_NOK_BIT] = cmd.done && !cmd.ok; // [R14]
        iclr = '0;
        if (do_wr && awaddr_q == OFS_IRQ_STAT && wstrb_q[0]) begin
            iclr = wdata_q[1:0];
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            istat_q <= '0;
            imask_q <= '0;
            irq_q <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~iclr) | ievt;
            if (do_wr && awaddr_q == OFS_IRQ_MASK && wstrb_q[0]) begin
                imask_q <= wdata_q[1:0];
            end
            irq_q <= |(istat_q & imask_q);
        end
    end

    assign S_AXI_AWREADY_O = awready_q;
    assign S_AXI_WREADY_O = wready_q;
    assign S_AXI_BVALID_O = bvalid_q;
    assign S_AXI_BRESP_O = bresp_q;
    assign S_AXI_ARREADY_O = arready_q;
    assign S_AXI_RVALID_O = rvalid_q;
    assign S_AXI_RDATA_O = rdata_q;
    assign S_AXI_RRESP_O = rresp_q;
    assign CFG_NODE_O = cmd.cfg_node;
    assign CFG_SEG_O = cmd.cfg_seg;
    assign IRQ_O = irq_q;

    chk_go_done: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // [R13]
        start_q |-> ##2 cmd.done ##1 (ok_q == $past(cmd.ok) && !busy_q))
        else $error("command did not complete in two cycles");
    chk_nok_irq: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // [R14]
        cmd.done && !cmd.ok |=> istat_q[IRQ_NOK_BIT] && istat_q[IRQ_DONE_BIT])
        else $error("nok event not flagged");
    chk_resp_capture: assert property (@(posedge CLK_I) disable iff (!ARST_N_I) // [R5]
        cmd.done |=> resp_q == $past(cmd.rdata) && resp_q[15:0] == 16'h0000)
        else $error("response not captured");
endmodule : anc_top
`default_nettype wire

// [tb/anc_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
module anc_master_model (
    input wire logic ok_en_i,
    input wire logic [5:0] cfg_node_i,
    input wire logic cfg_seg_i,
    output logic master_ok_o,
    output logic [127:0] act_list_o,
    output logic [127:0] det_list_o,
    output logic [15:0] act_cfg_o
);
    assign master_ok_o = ok_en_i;
    // bit 0 of response bytes 2 and 6 set here, so the read path must mask it off
    assign act_list_o = {64'h0123_4567_89ab_cdef, 64'h0};
    assign det_list_o = {64'h0, 64'hfedc_ba99_7654_3211};
    // echoes the pointed node so a stale pointer shows up
    assign act_cfg_o = {8'h96, 1'b0, cfg_seg_i, cfg_node_i};
endmodule : anc_master_model
`default_nettype wire

// [tb/anc_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module anc_tb_top;
    import anc_pkg::*;
    logic clk = 0, rst_n = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, mok = 1;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdata;
    logic [3:0] ws = 4'hf;
    logic [95:0] rsp;
    logic [1:0] bresp, rresp;
    logic bv, rv, awr, wrd, arr, irq, seg, m_ok;
    logic [127:0] al, dl;
    logic [15:0] ac;
    logic [5:0] node;
    int errors = 0, total_checks = 0, cyc = 0;

    anc_top anc_top_i (.CLK_I(clk), .ARST_N_I(rst_n), .S_AXI_AWADDR_I(awa),
        .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd),
        .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bry),
        .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
        .S_AXI_RREADY_I(rry), .MASTER_OK_I(m_ok), .ACT_LIST_I(al), .DET_LIST_I(dl),
        .ACT_CFG_I(ac), .CFG_NODE_O(node), .CFG_SEG_O(seg), .IRQ_O(irq));
    anc_master_model anc_master_model_i (.ok_en_i(mok), .cfg_node_i(node),
        .cfg_seg_i(seg), .master_ok_o(m_ok), .act_list_o(al), .det_list_o(dl),
        .act_cfg_o(ac));

    initial forever #2 clk = ~clk;

    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic chk(input logic [95:0] g, input logic [95:0] e);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awa <= a;
        wd <= d;
        ws <= 4'hf;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        r = bresp;
        bry <= 1'b0;
        @(posedge clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        d = rdata;
        r = rresp;
        rry <= 1'b0;
        @(posedge clk);
    endtask : axr

    // busy is polled so the bench assumes no fixed latency from launch to result
    task automatic cmd(input logic w, input logic [7:0] slot, input logic [7:0] idx,
                       input logic [95:0] d, output logic ok);
        logic [31:0] v;
        logic [1:0] r;
        for (int i = 0; i < 3; i++) axw(OFS_DATA0 + 8'(4 * i), d[32*i+:32], r);
        axw(OFS_REQ, {idx, REQ_PARAM, SUBSLOT_ID, slot}, r);
        axw(OFS_CTRL, {30'h0, w, 1'b1}, r);
        v = 32'h1;
        while (v[STAT_BUSY_BIT]) axr(OFS_STAT, v, r);
        ok = v[STAT_OK_BIT];
        for (int i = 0; i < 3; i++) axr(OFS_DATA0 + 8'(4 * i), rsp[32*i+:32], r);
    endtask : cmd

    // ****************************************
    // scenarios
    // ****************************************
    task automatic sc_config();
        logic ok;
        cmd(1'b1, SLOT_SEG1, 8'h44, 96'h25_0000, ok);
        // the node output picks up the pointer when the next command launches
        cmd(1'b1, SLOT_SEG1, 8'h08, 96'h7e3c_0000_0000, ok);
        chk({node, seg}, {6'h25, 1'b0});
        chk(ok, 1'b1);
        cmd(1'b0, SLOT_SEG1, 8'h09, 96'h0, ok);
        chk(rsp[31:0], 32'h7e3c_0000);
        cmd(1'b0, SLOT_SEG1, 8'h0b, 96'h0, ok);
        chk(rsp[31:0], 32'h2596_0000);
        mok <= 1'b0;
        cmd(1'b1, SLOT_SEG1, 8'h08, 96'h1111_0000_0000, ok);
        chk(ok, 1'b0);
        mok <= 1'b1;
        cmd(1'b0, SLOT_SEG1, 8'h09, 96'h0, ok);
        chk(rsp[31:0], 32'h7e3c_0000);
    endtask : sc_config

    task automatic sc_lists();
        logic ok;
        cmd(1'b1, SLOT_SEG2, 8'h0c, {16'h0, {8{8'hff}}, 16'h0}, ok);
        chk(ok, 1'b1);
        cmd(1'b0, SLOT_SEG2, 8'h0d, 96'h0, ok);
        chk(rsp, {16'h0, 64'hffff_fffe_ffff_fffe, 16'h0});
        cmd(1'b0, SLOT_SEG1, 8'h0d, 96'h0, ok);
        chk(rsp, 96'h0);
        cmd(1'b0, SLOT_SEG2, 8'h0e, 96'h0, ok);
        chk(rsp, {16'h0, 64'h0123_4566_89ab_cdee, 16'h0});
        chk({node, seg}, {6'h00, 1'b1});
        cmd(1'b0, SLOT_SEG1, 8'h0f, 96'h0, ok);
        chk(rsp, {16'h0, 64'hfedc_ba98_7654_3210, 16'h0});
    endtask : sc_lists

    task automatic sc_refuse();
        logic ok;
        cmd(1'b1, 8'h05, 8'h0c, {16'h0, 64'h5555_5555_5555_5555, 16'h0}, ok);
        chk(ok, 1'b0);
        cmd(1'b0, 8'h05, 8'h0d, 96'h0, ok);
        chk(rsp[95:88], 8'h01);
        cmd(1'b0, SLOT_SEG2, 8'h0a, 96'h0, ok);
        chk(ok, 1'b0);
        cmd(1'b0, SLOT_SEG2, 8'h0d, 96'h0, ok);
        chk(rsp[79:16], 64'hffff_fffe_ffff_fffe);
        // a bad slot would fall onto the first segment if it slipped through
        cmd(1'b0, SLOT_SEG1, 8'h0d, 96'h0, ok);
        chk(rsp[79:16], 64'h0);
    endtask : sc_refuse

    task automatic sc_irq_bus();
        logic [31:0] v;
        logic [1:0] r;
        axr(OFS_IRQ_STAT, v, r);
        chk(v[1:0], 2'b11);
        chk(irq, 1'b0);
        axw(OFS_IRQ_MASK, 32'h1, r);
        chk(irq, 1'b1);
        axw(OFS_IRQ_STAT, 32'h1, r);
        chk(irq, 1'b0);
        axr(OFS_IRQ_STAT, v, r);
        chk(v[1:0], 2'b10);
        axw(8'h20, 32'h5, r);
        chk(r, RESP_SLVERR);
        axr(8'h20, v, r);
        chk({r, v}, {RESP_SLVERR, 32'h0});
    endtask : sc_irq_bus

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        sc_config();
        sc_lists();
        sc_refuse();
        sc_irq_bus();
        report_and_stop();
    end
endmodule : anc_tb_top
`default_nettype wire
